// ==== include/lnu_params.svh ====
// Purpose: Offsets, field positions and reset values of the LIN channel control block
// Assumes: Register indices are word indices; byte address is four times the index
// Notes: Definitions only
`ifndef LNU_PARAMS_SVH
`define LNU_PARAMS_SVH

// Register word indices
`define LNU_IDX_CHAN_CTRL 12'hf43
`define LNU_IDX_CFG 12'hf40
`define LNU_IDX_IRQ_STAT 12'hf44
`define LNU_IDX_IRQ_MASK 12'hf45
`define LNU_IDX_LIVE 12'hf46

// Bank select values for the shared control index
`define LNU_BANK_FILTER 3'h1
`define LNU_BANK_LIN 3'h2

// Filter register fields
`define LNU_NF_EN_BIT 7
`define LNU_NF_WIDTH_LSB 4
`define LNU_NF_RO_MASK 8'h0f
`define LNU_NF_MIN_BITS 4
`define LNU_NF_MAX_BITS 11

// LIN mode register fields
`define LNU_LIN_MASTER_BIT 7
`define LNU_LIN_SLAVE_BIT 6
`define LNU_LIN_AB_EN_BIT 5
`define LNU_LIN_AB_IEN_BIT 4
`define LNU_LIN_PHASE_LSB 2
`define LNU_LIN_BREAK_LSB 0

// Configuration register fields
`define LNU_CFG_BANK_LSB 0
`define LNU_CFG_MP_BIT 3
`define LNU_CFG_PAR_BIT 4

// Interrupt event bits
`define LNU_EV_AUTOBAUD 0
`define LNU_EV_BREAK 1
`define LNU_EV_NUM 2

// Break lengths in bit times
`define LNU_BREAK_BITS_13 4'hd
`define LNU_BREAK_BITS_14 4'he

// Reset values
`define LNU_RST_BYTE 8'h00
`define LNU_RST_BANK 3'h0

`endif

// ==== include/lnu_pkg.sv ====
// Purpose: Types shared by the LIN channel control block
// Assumes: Constants live in lnu_params.svh
// Notes: Phase enum order matches the two-bit field encoding
package lnu_pkg;

    typedef enum logic [1:0] {
        PH_SLEEP,
        PH_WAIT_BREAK,
        PH_AUTOBAUD,
        PH_ACTIVE
    } lnu_phase_t;

    typedef enum logic [1:0] {
        ROLE_UART,
        ROLE_MASTER,
        ROLE_SLAVE
    } lnu_role_t;

endpackage

// ==== rtl/lnu_lin_ctrl.sv ====
// Purpose: APB register block for the receive noise filter and LIN mode control
// Assumes: All inputs synchronous to i_ref_clk; APB master holds the request until pready
// Notes: Each access takes two cycles in the access phase; registers sit in byte lane 0
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "lnu_params.svh"

// Overview of operation
// - Bank select value one maps the noise filter register onto the shared control index.
// - With the filter enable set, received data goes through the filter, otherwise it bypasses it.
// - The three-bit width code picks a filter counter of four up to eleven bits.
// - The low four bits of the filter register read zero and ignore writes, and software writes zeros.
// - Bank select value two maps the LIN mode register onto the shared control index.
// - The master bit selects master role only with multiprocessor, parity and slave bits clear.
// - The slave bit selects slave role only with multiprocessor, parity and master bits clear.
// - Autobaud enable acts only while the channel is a LIN slave.
// - In slave role with autobaud interrupt enable and the autobaud mask bit set, a finished autobaud raises an interrupt and the done flag.
// - The bus phase field encodes sleep, wait for break, autobaud and active, the middle two slave only.
// - In master role, break code zero gives thirteen bit times and code one gives fourteen.
module lnu_lin_ctrl
    import lnu_pkg::*;
(
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [15:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [3:0] i_pstrb,
    output logic o_pready,
    output logic [31:0] o_prdata,
    output logic o_pslverr,
    // Interrupt
    output logic o_irq,
    // Receive path
    input wire logic i_rx_raw,
    output logic o_rx_filtered,
    // Events from the receiver
    input wire logic i_break_seen,
    input wire logic i_autobaud_char_done,
    // Mode outputs to the UART datapath
    output logic o_lin_master,
    output logic o_lin_slave,
    output logic o_autobaud_run,
    output logic o_multiproc_en,
    output logic o_parity_en,
    output logic [1:0] o_bus_phase,
    output logic [3:0] o_break_bit_times
);

    // Role decode, shared by the mode flops and the phase machine
    function automatic lnu_role_t lnu_role(input logic master, input logic slave,
                                           input logic mp, input logic par);
        lnu_role_t r;
        r = ROLE_UART;
        if (!mp && !par) begin
            if (master && !slave) begin
                r = ROLE_MASTER;
            end else if (slave && !master) begin
                r = ROLE_SLAVE;
            end
        end
        return r;
    endfunction

    // Address decode, used for the read mux and for the write strobes
    function automatic logic lnu_hit(input logic [15:0] addr, input logic [11:0] idx);
        return (addr[1:0] == 2'b00) && (addr[15:14] == 2'b00) && (addr[13:2] == idx);
    endfunction

    // Registers
    localparam logic [7:0] RST_FILTER = `LNU_RST_BYTE;
    logic [2:0] bank_q;
    logic multiproc_q;
    logic parity_q;
    logic nf_en_q;
    logic [2:0] nf_width_q;
    logic lin_master_q;
    logic lin_slave_q;
    logic ab_en_q;
    logic ab_ien_q;
    lnu_phase_t phase_q;
    lnu_phase_t phase_d;
    logic [1:0] break_code_q;
    logic [`LNU_EV_NUM-1:0] irq_stat_q;
    logic [`LNU_EV_NUM-1:0] irq_mask_q;
    logic [`LNU_EV_NUM-1:0] events;
    logic [`LNU_EV_NUM-1:0] rd_clr;
    logic [`LNU_EV_NUM-1:0] irq_live;

    // Bus handshake
    logic pready_q;
    logic [31:0] prdata_q;
    logic pslverr_q;
    logic [7:0] rd_byte;
    logic rd_mapped;
    logic acc_start;
    logic acc_done;
    logic wr_lane0;
    logic wr_chan;
    logic wr_filter;
    logic wr_lin;
    logic wr_cfg;
    logic wr_mask;
    logic rd_stat_done;

    // Mode flops
    lnu_role_t role;
    logic lin_master_o_q;
    logic lin_slave_o_q;
    logic ab_run_q;
    logic irq_q;
    logic [3:0] break_bits_q;
    logic [7:0] lin_byte;
    logic [7:0] filter_byte;

    assign acc_start = i_psel && i_penable && !pready_q;
    assign acc_done = i_psel && i_penable && pready_q;
    assign wr_lane0 = acc_done && i_pwrite && i_pstrb[0];
    assign wr_chan = wr_lane0 && lnu_hit(i_paddr, `LNU_IDX_CHAN_CTRL);
    assign wr_filter = wr_chan && (bank_q == `LNU_BANK_FILTER);
    assign wr_lin = wr_chan && (bank_q == `LNU_BANK_LIN);
    assign wr_cfg = wr_lane0 && lnu_hit(i_paddr, `LNU_IDX_CFG);
    assign wr_mask = wr_lane0 && lnu_hit(i_paddr, `LNU_IDX_IRQ_MASK);
    assign rd_stat_done = acc_done && !i_pwrite && lnu_hit(i_paddr, `LNU_IDX_IRQ_STAT);

    assign filter_byte = {nf_en_q, nf_width_q, 4'h0};
    assign lin_byte = {lin_master_q, lin_slave_q, ab_en_q, ab_ien_q, phase_q, break_code_q};

    // Read mux, captured at the first access edge
    always_comb begin
        rd_byte = 8'h00;
        rd_mapped = 1'b1;
        if (lnu_hit(i_paddr, `LNU_IDX_CHAN_CTRL)) begin
            if (bank_q == `LNU_BANK_FILTER) begin
                rd_byte = filter_byte;
            end else if (bank_q == `LNU_BANK_LIN) begin
                rd_byte = lin_byte;
            end
        end else if (lnu_hit(i_paddr, `LNU_IDX_CFG)) begin
            rd_byte = {3'h0, parity_q, multiproc_q, bank_q};
        end else if (lnu_hit(i_paddr, `LNU_IDX_IRQ_STAT)) begin
            rd_byte = {6'h00, irq_stat_q};
        end else if (lnu_hit(i_paddr, `LNU_IDX_IRQ_MASK)) begin
            rd_byte = {6'h00, irq_mask_q};
        end else if (lnu_hit(i_paddr, `LNU_IDX_LIVE)) begin
            rd_byte = {2'h0, ab_run_q, lin_slave_o_q, lin_master_o_q, o_rx_filtered, irq_q, 1'b0};
        end else begin
            rd_mapped = 1'b0;
        end
    end

    // APB answer: pready one cycle after the access phase opens
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            pready_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else if (acc_start) begin
            pready_q <= 1'b1;
            prdata_q <= i_pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
            pslverr_q <= !rd_mapped;
        end else begin
            pready_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end
    end

    // Configuration register
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            bank_q <= `LNU_RST_BANK;
            multiproc_q <= 1'b0;
            parity_q <= 1'b0;
        end else if (wr_cfg) begin
            bank_q <= i_pwdata[`LNU_CFG_BANK_LSB +: 3];
            multiproc_q <= i_pwdata[`LNU_CFG_MP_BIT];
            parity_q <= i_pwdata[`LNU_CFG_PAR_BIT];
        end
    end

    // Noise filter register
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            nf_en_q <= RST_FILTER[`LNU_NF_EN_BIT];
            nf_width_q <= RST_FILTER[`LNU_NF_WIDTH_LSB +: 3];
        end else if (wr_filter) begin
            nf_en_q <= i_pwdata[`LNU_NF_EN_BIT];
            nf_width_q <= i_pwdata[`LNU_NF_WIDTH_LSB +: 3];
        end
    end

    // LIN mode register, phase kept apart since hardware moves it too
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            lin_master_q <= 1'b0;
            lin_slave_q <= 1'b0;
            ab_en_q <= 1'b0;
            ab_ien_q <= 1'b0;
            break_code_q <= 2'b00;
        end else if (wr_lin) begin
            lin_master_q <= i_pwdata[`LNU_LIN_MASTER_BIT];
            lin_slave_q <= i_pwdata[`LNU_LIN_SLAVE_BIT];
            ab_en_q <= i_pwdata[`LNU_LIN_AB_EN_BIT];
            ab_ien_q <= i_pwdata[`LNU_LIN_AB_IEN_BIT];
            break_code_q <= i_pwdata[`LNU_LIN_BREAK_LSB +: 2];
        end
    end

    assign role = lnu_role(lin_master_q, lin_slave_q, multiproc_q, parity_q);

    // Phase machine; a software write forces the state over hardware
    always_comb begin
        phase_d = phase_q;
        if (wr_lin) begin
            phase_d = lnu_phase_t'(i_pwdata[`LNU_LIN_PHASE_LSB +: 2]);
        end else if (role == ROLE_SLAVE) begin
            // slave cycles through break and autobaud
            unique case (phase_q)
                PH_SLEEP: begin
                    phase_d = PH_SLEEP;
                end
                PH_WAIT_BREAK: begin
                    if (i_break_seen) begin
                        phase_d = ab_en_q ? PH_AUTOBAUD : PH_ACTIVE;
                    end
                end
                PH_AUTOBAUD: begin
                    if (!ab_en_q || i_autobaud_char_done) begin
                        phase_d = PH_ACTIVE;
                    end
                end
                PH_ACTIVE: begin
                    if (i_break_seen && ab_en_q) begin
                        phase_d = PH_AUTOBAUD;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            phase_q <= PH_SLEEP;
        end else begin
            phase_q <= phase_d;
        end
    end

    // Events: break while waiting or active, autobaud character finished
    always_comb begin
        events = '0;
        events[`LNU_EV_BREAK] = i_break_seen && (role == ROLE_SLAVE) &&
            (phase_q == PH_WAIT_BREAK || phase_q == PH_ACTIVE);
        events[`LNU_EV_AUTOBAUD] = i_autobaud_char_done && (role == ROLE_SLAVE) && ab_en_q &&
            (phase_q == PH_AUTOBAUD);
    end

    // Clear only what the read returned; a new event still wins
    assign rd_clr = rd_stat_done ? prdata_q[`LNU_EV_NUM-1:0] : '0;

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            irq_stat_q <= '0;
        end else begin
            irq_stat_q <= (irq_stat_q & ~rd_clr) | events;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            irq_mask_q <= '0;
        end else if (wr_mask) begin
            irq_mask_q <= i_pwdata[`LNU_EV_NUM-1:0];
        end
    end

    // autobaud irq needs its enable and slave role
    always_comb begin
        irq_live = irq_stat_q & irq_mask_q;
        irq_live[`LNU_EV_AUTOBAUD] = irq_live[`LNU_EV_AUTOBAUD] && ab_ien_q && (role == ROLE_SLAVE);
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |irq_live;
        end
    end

    // Role and mode outputs, registered
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            lin_master_o_q <= 1'b0;
            lin_slave_o_q <= 1'b0;
            ab_run_q <= 1'b0;
        end else begin
            lin_master_o_q <= (role == ROLE_MASTER);
            lin_slave_o_q <= (role == ROLE_SLAVE);
            // measure only as slave in autobaud
            ab_run_q <= (role == ROLE_SLAVE) && ab_en_q && (phase_q == PH_AUTOBAUD);
        end
    end

    // Break length; codes above one are left at thirteen bits
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            break_bits_q <= `LNU_BREAK_BITS_13;
        end else begin
            break_bits_q <= (break_code_q == 2'b01) ? `LNU_BREAK_BITS_14 : `LNU_BREAK_BITS_13;
        end
    end

    lnu_rx_filter u_rx_filter (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_enable(nf_en_q),
        .i_width_code(nf_width_q),
        .i_rx_raw(i_rx_raw),
        .o_rx_filtered(o_rx_filtered)
    );

    assign o_pready = pready_q;
    assign o_prdata = prdata_q;
    assign o_pslverr = pslverr_q;
    assign o_irq = irq_q;
    assign o_lin_master = lin_master_o_q;
    assign o_lin_slave = lin_slave_o_q;
    assign o_autobaud_run = ab_run_q;
    assign o_multiproc_en = multiproc_q;
    assign o_parity_en = parity_q;
    assign o_bus_phase = phase_q;
    assign o_break_bit_times = break_bits_q;

endmodule
`default_nettype wire

// ==== rtl/lnu_rx_filter.sv ====
// Purpose: Saturating up/down counter noise filter on the receive line
// Assumes: Receive input already synchronous to the clock
// Notes: Bypassed when disabled; counter tracks the raw line for a clean enable
`timescale 1ns/1ps
`default_nettype none
`include "lnu_params.svh"

module lnu_rx_filter (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // Control
    input wire logic i_enable,
    input wire logic [2:0] i_width_code,
    // Data
    input wire logic i_rx_raw,
    output logic o_rx_filtered
);

    logic [10:0] cnt_q;
    logic [10:0] cnt_d;
    logic [10:0] full_scale;
    logic out_q;
    logic out_d;

    always_comb begin
        full_scale = 11'(({11'h000, 1'b1} << (`LNU_NF_MIN_BITS + 32'(i_width_code))) - 12'h001);
    end

    always_comb begin
        cnt_d = cnt_q;
        out_d = out_q;
        if (!i_enable) begin
            cnt_d = i_rx_raw ? full_scale : 11'h000;
            out_d = i_rx_raw;
        end else if (cnt_q > full_scale) begin
            // Narrowed width; clamp so saturation still works
            cnt_d = full_scale;
        end else begin
            if (i_rx_raw && cnt_q != full_scale) begin
                cnt_d = cnt_q + 11'h001;
            end else if (!i_rx_raw && cnt_q != 11'h000) begin
                cnt_d = cnt_q - 11'h001;
            end
            if (cnt_d == full_scale) begin
                out_d = 1'b1;
            end else if (cnt_d == 11'h000) begin
                out_d = 1'b0;
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            cnt_q <= 11'h7ff;
            out_q <= 1'b1;
        end else begin
            cnt_q <= cnt_d;
            out_q <= out_d;
        end
    end

    assign o_rx_filtered = out_q;

endmodule
`default_nettype wire

// ==== verif/lnu_lin_ctrl_asserts.sv ====
// Purpose: Port-level checks of the LIN channel control block
// Assumes: One clock domain, synchronous active-high reset
// Notes: The mp and parity role checks look at the rising edge only, since role outputs lag the registers
`timescale 1ns/1ps
`default_nettype none

module lnu_lin_ctrl_asserts (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // APB
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic o_pready,
    input wire logic [31:0] o_prdata,
    input wire logic o_pslverr,
    // Receive path and modes
    input wire logic i_rx_raw,
    input wire logic o_rx_filtered,
    input wire logic o_lin_master,
    input wire logic o_lin_slave,
    input wire logic o_autobaud_run,
    input wire logic o_multiproc_en,
    input wire logic o_parity_en,
    input wire logic [3:0] o_break_bit_times
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);

    a_ready_after_access: assert property (i_psel && i_penable && !o_pready |=> o_pready)
        else $error("ready missing after access");
    a_ready_one_cycle: assert property (o_pready |=> !o_pready)
        else $error("ready held too long");
    a_ready_needs_sel: assert property (!i_psel |=> !o_pready)
        else $error("ready without select");
    a_read_data_clean: assert property ((o_prdata[31:8] == 24'h0) && (o_pready || o_prdata == 32'h0))
        else $error("read data outside its slot");
    a_err_with_ready: assert property (o_pslverr |-> o_pready && o_prdata == 32'h0)
        else $error("error flag misplaced");
    a_roles_apart: assert property (!(o_lin_master && o_lin_slave))
        else $error("both roles at once");
    a_master_clear: assert property ($rose(o_lin_master) |-> !o_multiproc_en && !o_parity_en)
        else $error("master with mp or parity");
    a_slave_clear: assert property ($rose(o_lin_slave) |-> !o_multiproc_en && !o_parity_en)
        else $error("slave with mp or parity");
    a_break_legal: assert property (o_break_bit_times inside {4'hd, 4'he})
        else $error("break length illegal");
    a_autobaud_slave: assert property (o_autobaud_run |-> o_lin_slave || $past(o_lin_slave))
        else $error("autobaud outside slave role");
    a_filter_follows: assert property ($changed(o_rx_filtered) |-> o_rx_filtered == $past(i_rx_raw))
        else $error("filtered line moved against input");

    cover property (o_pslverr);
    cover property (o_autobaud_run);
    cover property ($fell(o_rx_filtered));
endmodule

bind lnu_lin_ctrl lnu_lin_ctrl_asserts u_asserts (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable),
    .o_pready(o_pready), .o_prdata(o_prdata), .o_pslverr(o_pslverr), .i_rx_raw(i_rx_raw),
    .o_rx_filtered(o_rx_filtered), .o_lin_master(o_lin_master), .o_lin_slave(o_lin_slave),
    .o_autobaud_run(o_autobaud_run), .o_multiproc_en(o_multiproc_en), .o_parity_en(o_parity_en),
    .o_break_bit_times(o_break_bit_times));
`default_nettype wire

// ==== verif/lnu_lin_ctrl_tb.sv ====
// Purpose: Self-checking bench of the LIN channel control block
// Assumes: APB answer comes two cycles into the access phase
// Notes: Reads sample design outputs at the edge, before that edge's updates land
`timescale 1ns/1ps
`default_nettype none
`include "lnu_params.svh"

module lnu_lin_ctrl_tb;
    localparam logic [15:0] ADR_CH = {2'b0, `LNU_IDX_CHAN_CTRL, 2'b0};
    localparam logic [15:0] ADR_CFG = {2'b0, `LNU_IDX_CFG, 2'b0};
    localparam logic [15:0] ADR_ST = {2'b0, `LNU_IDX_IRQ_STAT, 2'b0};
    localparam logic [15:0] ADR_MK = {2'b0, `LNU_IDX_IRQ_MASK, 2'b0};
    localparam logic [15:0] ADR_LV = {2'b0, `LNU_IDX_LIVE, 2'b0};
    localparam logic [7:0] ROLE_CFG [7] = '{8'h02, 8'h02, 8'h02, 8'h0a, 8'h12, 8'h0a, 8'h12};
    localparam logic [7:0] ROLE_LIN [7] = '{8'h80, 8'h40, 8'hc0, 8'h80, 8'h40, 8'h40, 8'h80};
    localparam logic [1:0] ROLE_EXP [7] = '{2'b10, 2'b01, 2'b00, 2'b00, 2'b00, 2'b00, 2'b00};
    logic clk, rst, psel, penable, pwrite, pready, pslverr, irq;
    logic rx, rxf, brk, abd, mst, slv, abr, mp, par;
    logic [1:0] ph;
    logic [3:0] bt, pstrb;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata;
    int bad_count = 0;
    int tests_run = 0;

    lnu_lin_ctrl uut (.i_ref_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb), .o_pready(pready),
        .o_prdata(prdata), .o_pslverr(pslverr), .o_irq(irq), .i_rx_raw(rx), .o_rx_filtered(rxf),
        .i_break_seen(brk), .i_autobaud_char_done(abd), .o_lin_master(mst), .o_lin_slave(slv),
        .o_autobaud_run(abr), .o_multiproc_en(mp), .o_parity_en(par), .o_bus_phase(ph),
        .o_break_bit_times(bt));
    lnu_lin_peer u_peer (.i_ref_clk(clk), .o_rx(rx), .o_break(brk), .o_ab_done(abd));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic end_sim();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input logic [32:0] g, input logic [32:0] x);
        tests_run++;
        if (g !== x) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, g, x);
        end
    endtask

    // Master holds every request signal until ready is seen at an edge
    task automatic apb(input logic w, input logic [15:0] a, input logic [7:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        pstrb <= 4'h1;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk(33'(n), 33'h2);
        // Idle edge, so the next setup never reassigns psel in this step
        @(posedge clk);
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
        chk({32'h0, e}, 33'h0);
    endtask

    task automatic rd(input logic [15:0] a, input logic [7:0] x);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 8'h0, r, e);
        chk({e, r}, {25'h0, x});
    endtask

    task automatic t_reset();
        chk(33'({rxf, bt, mst, slv, irq, abr}), 33'h1d0);
        rd(ADR_CFG, 8'h00);
        rd(ADR_CH, 8'h00);
        rd(ADR_ST, 8'h00);
        rd(ADR_MK, 8'h00);
        rd(ADR_LV, 8'h04);
        $display("test reset done");
    endtask

    task automatic t_banks();
        logic [31:0] r;
        logic e;
        wr(ADR_CFG, 8'h01);
        rd(ADR_CH, 8'h00);
        wr(ADR_CH, 8'hf0);
        rd(ADR_CH, 8'hf0);
        wr(ADR_CFG, 8'h02);
        rd(ADR_CH, 8'h00);
        wr(ADR_CH, 8'h93);
        rd(ADR_CH, 8'h93);
        wr(ADR_CFG, 8'h00);
        rd(ADR_CH, 8'h00);
        wr(ADR_CH, 8'h5a);
        wr(ADR_CFG, 8'h01);
        rd(ADR_CH, 8'hf0);
        wr(ADR_CFG, 8'h02);
        rd(ADR_CH, 8'h93);
        apb(1'b0, 16'h3d1c, 8'h0, r, e);
        chk({e, r}, {1'b1, 32'h0});
        apb(1'b1, 16'h3d0d, 8'hff, r, e);
        chk({e, r}, {1'b1, 32'h0});
        rd(ADR_CH, 8'h93);
        $display("test banks done");
    endtask

    task automatic t_roles();
        for (int k = 0; k < 7; k++) begin
            wr(ADR_CFG, ROLE_CFG[k]);
            wr(ADR_CH, ROLE_LIN[k]);
            repeat (2) @(posedge clk);
            chk(33'({mst, slv, mp, par}), 33'({ROLE_EXP[k], ROLE_CFG[k][3], ROLE_CFG[k][4]}));
        end
        $display("test roles done");
    endtask

    task automatic t_break();
        wr(ADR_CFG, 8'h02);
        for (int k = 0; k < 4; k++) begin
            wr(ADR_CH, 8'h80 | 8'(k));
            repeat (2) @(posedge clk);
            chk(33'(bt), (k == 1) ? 33'he : 33'hd);
        end
        $display("test break done");
    endtask

    task automatic t_filter();
        int f;
        int n;
        wr(ADR_CFG, 8'h01);
        wr(ADR_CH, 8'h00);
        u_peer.line(1'b0, 2);
        chk(33'(rxf), 33'h0);
        u_peer.line(1'b1, 2);
        chk(33'(rxf), 33'h1);
        for (int c = 0; c < 8; c++) begin
            f = (1 << (4 + c)) - 1;
            wr(ADR_CH, 8'h80 | 8'(c << 4));
            u_peer.line(1'b1, f + 4);
            // Noise one sample short of full scale is rejected
            u_peer.line(1'b0, f - 1);
            chk(33'(rxf), 33'h1);
            u_peer.line(1'b1, f + 4);
            u_peer.line(1'b0, 0);
            n = 0;
            while (rxf !== 1'b0 && n < 3000) begin
                @(posedge clk);
                n++;
            end
            chk(33'(n), 33'(f + 1));
        end
        u_peer.line(1'b1, 4);
        $display("test filter done");
    endtask

    task automatic ev(input logic [7:0] lin, input logic [1:0] mask, input logic [2:0] run_ph,
                      input logic [1:0] st, input logic ex_irq);
        wr(ADR_CFG, 8'h02);
        wr(ADR_MK, {6'h0, mask});
        wr(ADR_CH, lin);
        repeat (2) @(posedge clk);
        u_peer.pulse(1'b1);
        repeat (3) @(posedge clk);
        chk(33'({abr, ph}), 33'(run_ph));
        u_peer.pulse(1'b0);
        repeat (3) @(posedge clk);
        chk(33'(irq), 33'(ex_irq));
        rd(ADR_ST, {6'h0, st});
        repeat (3) @(posedge clk);
        chk(33'(irq), 33'h0);
        rd(ADR_ST, 8'h00);
    endtask

    task automatic t_events();
        ev(8'h74, 2'h1, 3'b110, 2'h3, 1'b1);
        ev(8'h74, 2'h0, 3'b110, 2'h3, 1'b0);
        ev(8'h64, 2'h1, 3'b110, 2'h3, 1'b0);
        ev(8'h54, 2'h1, 3'b011, 2'h2, 1'b0);
        ev(8'hbc, 2'h1, 3'b011, 2'h0, 1'b0);
        $display("test events done");
    endtask

    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 16'h0;
        pwdata = 32'h0;
        pstrb = 4'h0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_banks();
        t_roles();
        t_break();
        t_filter();
        t_events();
        end_sim();
    end

    // Run needs about 17000 cycles; cut off at 100000
    initial begin
        #400000;
        bad_count++;
        $display("watchdog expired at %0t", $time);
        end_sim();
    end
endmodule
`default_nettype wire

// ==== verif/lnu_lin_peer.sv ====
// Purpose: Far-side model: bus line through the transceiver and receiver event pulses
// Assumes: Called just after a rising clock edge
// Notes: Idle bus is recessive high, so the line rests at 1
`timescale 1ns/1ps
`default_nettype none

module lnu_lin_peer (
    // Clock
    input wire logic i_ref_clk,
    // Toward the block
    output logic o_rx,
    output logic o_break,
    output logic o_ab_done
);
    initial begin
        o_rx = 1'b1;
        o_break = 1'b0;
        o_ab_done = 1'b0;
    end

    task automatic line(input logic v, input int n);
        o_rx <= v;
        repeat (n) @(posedge i_ref_clk);
    endtask

    // One-cycle pulse: break when b is set, else autobaud done
    task automatic pulse(input logic b);
        if (b) o_break <= 1'b1;
        else o_ab_done <= 1'b1;
        @(posedge i_ref_clk);
        o_break <= 1'b0;
        o_ab_done <= 1'b0;
    endtask
endmodule
`default_nettype wire
